/* File: hdl/phy_cfg_pkg.sv */
// constants and carrier types for the transceiver configuration and test block
package phy_cfg_pkg;

    // --------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------------
    localparam logic [4:0] BASIC_CTRL_IDX = 5'h00;
    localparam logic [4:0] PHY_STATUS_IDX = 5'h10;
    localparam logic [4:0] PHY_CTRL_IDX = 5'h19;
    localparam int ADDR_W = 12;

    // --------------------------------------------------------------------
    // basic control fields
    // --------------------------------------------------------------------
    localparam int BC_LOOPBACK = 14;
    localparam int BC_SPEED100 = 13;
    localparam int BC_AN_ENABLE = 12;
    localparam int BC_ISOLATE = 10;
    localparam int BC_FULL_DUPLEX = 8;
    localparam logic [15:0] BASIC_CTRL_WMASK = 16'h7500;
    localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;

    // --------------------------------------------------------------------
    // phy status fields
    // --------------------------------------------------------------------
    localparam int PS_LINK = 0;
    localparam int PS_SPEED10 = 1;
    localparam int PS_FULL_DUPLEX = 2;
    localparam int PS_LOOPBACK = 3;
    localparam int PS_ISOLATE = 4;

    // --------------------------------------------------------------------
    // phy control fields
    // --------------------------------------------------------------------
    localparam int PC_ADDR_LSB = 0;
    localparam int PC_BIST_STATUS = 8;
    localparam int PC_BIST_START = 9;
    localparam int PC_PRBS_LONG = 10;
    localparam logic [15:0] PHY_CTRL_RST = 16'h0000;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int LINK_PULSES_NEEDED = 7;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [2:0] BIST_WARM_NIBBLES = 3'h4;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;

    // --------------------------------------------------------------------
    // carrier types
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] data;
        logic en;
        logic er;
    } mii_nibble_t;

    typedef enum logic [1:0] {
        STRAP_WAIT,
        STRAP_DONE
    } strap_state_t;

endpackage : phy_cfg_pkg

/* File: hdl/phy_led_isolate_loopback_bist.sv */
// indicator, duplex, isolate, loopback and self-test logic of a 10/100 transceiver
`timescale 1ns/1ns
module phy_led_isolate_loopback_bist #(
    parameter int LINK_LOSS_CYCLES = 25000000
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [4:0] ADDRESS_STRAP_INPUT,
    output logic [4:0] ADDRESS_STRAP_OUT,
    output logic [4:0] ADDRESS_STRAP_OE_B,
    input wire logic INDICATOR_POLARITY_STRAP,
    output logic SPEED_INDICATOR_OUT,
    input wire logic AN_SPEED100,
    input wire logic AN_FULL_DUPLEX,
    input wire logic AN_PARALLEL_DETECT,
    input wire logic SIGNAL_DETECT,
    input wire logic NORMAL_LINK_PULSE,
    input wire logic VALID_PACKET,
    input wire logic MII_LINK_CLK,
    input wire logic [3:0] TXD,
    input wire logic TX_EN,
    input wire logic TX_ER,
    output logic TX_CLK,
    output logic RX_CLK,
    output logic [3:0] RXD,
    output logic RX_DV,
    output logic RX_ER,
    output logic CRS,
    output logic COL,
    output logic MII_OE_B,
    input wire logic [3:0] LINE_RXD,
    input wire logic LINE_RX_DV,
    input wire logic LINE_RX_ER,
    output logic [3:0] LINE_TXD,
    output logic LINE_TX_EN,
    output logic LINE_TX_ER,
    output logic LINE_LINK_PULSE_EN,
    output logic LINE_LOOP_PMD
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [14:0] prbs_nibble(input logic [14:0] s, input logic long_seq);
        logic [14:0] t;
        t = s;
        for (int i = 0; i < 4; i++) begin
            t = {t[13:0], long_seq ? (t[14] ^ t[13]) : (t[8] ^ t[4])};
        end
        return t;
    endfunction : prbs_nibble

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [4:0] strap_s1_q, strap_s2_q;
    logic pol_s1_q, pol_s2_q;
    logic [2:0] lclk_s1_q, lclk_s2_q;
    logic [5:0] tx_s1_q, tx_s2_q;
    logic [2:0] ln_s1_q, ln_s2_q;
    logic lclk_d1_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_s1_q <= 5'h00;
            strap_s2_q <= 5'h00;
            pol_s1_q <= 1'b0;
            pol_s2_q <= 1'b0;
            lclk_s1_q <= 3'h0;
            lclk_s2_q <= 3'h0;
            tx_s1_q <= 6'h00;
            tx_s2_q <= 6'h00;
            ln_s1_q <= 3'h0;
            ln_s2_q <= 3'h0;
            lclk_d1_q <= 1'b0;
        end else begin
            strap_s1_q <= ADDRESS_STRAP_INPUT;
            strap_s2_q <= strap_s1_q;
            pol_s1_q <= INDICATOR_POLARITY_STRAP;
            pol_s2_q <= pol_s1_q;
            lclk_s1_q <= {MII_LINK_CLK, 2'b00};
            lclk_s2_q <= lclk_s1_q;
            tx_s1_q <= {TXD, TX_EN, TX_ER};
            tx_s2_q <= tx_s1_q;
            ln_s1_q <= {SIGNAL_DETECT, NORMAL_LINK_PULSE, VALID_PACKET};
            ln_s2_q <= ln_s1_q;
            lclk_d1_q <= lclk_s2_q[2];
        end
    end

    wire mii_en = lclk_s2_q[2] & ~lclk_d1_q;
    wire sig_detect = ln_s2_q[2];
    wire pulse_lvl = ln_s2_q[1];
    wire packet_lvl = ln_s2_q[0];

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    phy_cfg_pkg::strap_state_t strap_st_q;
    logic [1:0] settle_q;
    logic [4:0] strap_q;
    logic pol_strap_q;
    logic strap_zero_q;

    wire strap_take = (strap_st_q == phy_cfg_pkg::STRAP_WAIT) &&
                      (settle_q == phy_cfg_pkg::STRAP_SETTLE);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_st_q <= phy_cfg_pkg::STRAP_WAIT;
            settle_q <= 2'h0;
        end else if (strap_st_q == phy_cfg_pkg::STRAP_WAIT) begin
            settle_q <= settle_q + 2'h1;
            if (strap_take) begin
                strap_st_q <= phy_cfg_pkg::STRAP_DONE;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_q <= 5'h00;
            pol_strap_q <= 1'b0;
            strap_zero_q <= 1'b0;
        end else if (strap_take) begin
            strap_q <= strap_s2_q;
            pol_strap_q <= pol_s2_q;
            strap_zero_q <= (strap_s2_q == 5'h00);
        end
    end

    wire straps_done = (strap_st_q == phy_cfg_pkg::STRAP_DONE);

    // ------------------------------------------------------------------
    // registers and APB slave
    // ------------------------------------------------------------------
    logic [15:0] basic_control_reg_q;
    logic [15:0] phy_control_reg_q;
    logic bist_ok_q;

    wire [9:0] reg_idx = PADDR[11:2];
    wire hit_bc = (reg_idx == {5'h00, phy_cfg_pkg::BASIC_CTRL_IDX});
    wire hit_ps = (reg_idx == {5'h00, phy_cfg_pkg::PHY_STATUS_IDX});
    wire hit_pc = (reg_idx == {5'h00, phy_cfg_pkg::PHY_CTRL_IDX});
    wire hit_any = hit_bc | hit_ps | hit_pc;
    wire apb_wr = PSEL & PENABLE & PWRITE & hit_any;
    wire pc_wr = apb_wr & hit_pc;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            basic_control_reg_q <= phy_cfg_pkg::BASIC_CTRL_RST;
        end else if (apb_wr && hit_bc) begin
            basic_control_reg_q <= PWDATA[15:0] & phy_cfg_pkg::BASIC_CTRL_WMASK;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            phy_control_reg_q <= phy_cfg_pkg::PHY_CTRL_RST;
        end else if (strap_take) begin
            phy_control_reg_q[4:0] <= strap_s2_q;
        end else if (pc_wr) begin
            phy_control_reg_q[4:0] <= PWDATA[4:0];
            phy_control_reg_q[phy_cfg_pkg::PC_BIST_START] <= PWDATA[phy_cfg_pkg::PC_BIST_START];
            phy_control_reg_q[phy_cfg_pkg::PC_PRBS_LONG] <= PWDATA[phy_cfg_pkg::PC_PRBS_LONG];
        end
    end

    // ------------------------------------------------------------------
    // operating mode resolution
    // ------------------------------------------------------------------
    wire an_on = basic_control_reg_q[phy_cfg_pkg::BC_AN_ENABLE];
    wire loopback = basic_control_reg_q[phy_cfg_pkg::BC_LOOPBACK];
    wire speed100 = an_on ? AN_SPEED100 : basic_control_reg_q[phy_cfg_pkg::BC_SPEED100];
    wire full_dup = an_on ? (AN_FULL_DUPLEX & ~AN_PARALLEL_DETECT)
                          : basic_control_reg_q[phy_cfg_pkg::BC_FULL_DUPLEX];
    wire isolate = basic_control_reg_q[phy_cfg_pkg::BC_ISOLATE] | strap_zero_q;
    wire bist_run = phy_control_reg_q[phy_cfg_pkg::PC_BIST_START];
    wire prbs_long = phy_control_reg_q[phy_cfg_pkg::PC_PRBS_LONG];

    // ------------------------------------------------------------------
    // link status
    // ------------------------------------------------------------------
    logic [24:0] loss_cnt_q;
    logic [2:0] pulse_cnt_q;
    logic link10_q;
    logic pulse_d1_q, packet_d1_q;
    localparam int LINK_PULSES_NEEDED_M1 = phy_cfg_pkg::LINK_PULSES_NEEDED - 1;

    wire pulse_ev = pulse_lvl & ~pulse_d1_q;
    wire packet_ev = packet_lvl & ~packet_d1_q;
    wire loss_hit = (loss_cnt_q == 25'(LINK_LOSS_CYCLES - 1));

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            loss_cnt_q <= 25'h0000000;
            pulse_cnt_q <= 3'h0;
            link10_q <= 1'b0;
            pulse_d1_q <= 1'b0;
            packet_d1_q <= 1'b0;
        end else begin
            pulse_d1_q <= pulse_lvl;
            packet_d1_q <= packet_lvl;
            if (pulse_ev || packet_ev) begin
                loss_cnt_q <= 25'h0000000;
            end else if (!loss_hit) begin
                loss_cnt_q <= loss_cnt_q + 25'h0000001;
            end
            if (packet_ev) begin
                link10_q <= 1'b1;
            end else if (pulse_ev) begin
                if (pulse_cnt_q == 3'(LINK_PULSES_NEEDED_M1)) begin
                    link10_q <= 1'b1;
                end else begin
                    pulse_cnt_q <= pulse_cnt_q + 3'h1;
                end
            end else if (loss_hit) begin
                pulse_cnt_q <= 3'h0;
                link10_q <= 1'b0;
            end
        end
    end

    wire link_good = speed100 ? sig_detect : link10_q;

    // ------------------------------------------------------------------
    // MII datapath, loopback and line transmit
    // ------------------------------------------------------------------
    phy_cfg_pkg::mii_nibble_t tx_in, line_rx;
    phy_cfg_pkg::mii_nibble_t tx_q, rx_q, line_tx_q;
    logic [14:0] prbs_tx_q;
    logic crs_q, col_q;

    assign tx_in = isolate ? '0 : tx_s2_q;
    assign line_rx = '{data: LINE_RXD, en: LINE_RX_DV, er: LINE_RX_ER};
    wire [14:0] prbs_next = prbs_nibble(prbs_tx_q, prbs_long);
    wire phy_tx_en = bist_run | tx_in.en;
    wire rx_act = loopback ? phy_tx_en : LINE_RX_DV;
    wire crs_d = full_dup ? rx_act : (rx_act | phy_tx_en);
    wire col_d = ~full_dup & rx_act & phy_tx_en & ~loopback;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prbs_tx_q <= phy_cfg_pkg::PRBS_SEED;
            tx_q <= '0;
            rx_q <= '0;
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else if (mii_en) begin
            if (bist_run) begin
                prbs_tx_q <= prbs_next;
                tx_q <= '{data: prbs_next[3:0], en: 1'b1, er: 1'b0};
            end else begin
                tx_q <= tx_in;
            end
            rx_q <= loopback ? tx_q : line_rx;
            crs_q <= crs_d;
            col_q <= col_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            line_tx_q <= '0;
        end else if (mii_en || isolate || LINE_LOOP_PMD) begin
            line_tx_q <= (isolate || LINE_LOOP_PMD) ? '0 : tx_q;
        end
    end

    assign RXD = rx_q.data;
    assign RX_DV = rx_q.en;
    assign RX_ER = rx_q.er;
    assign CRS = crs_q;
    assign COL = col_q;
    assign TX_CLK = lclk_s2_q[2];
    assign RX_CLK = lclk_s2_q[2];
    assign MII_OE_B = isolate;
    assign LINE_TXD = line_tx_q.data;
    assign LINE_TX_EN = line_tx_q.en;
    assign LINE_TX_ER = line_tx_q.er;
    assign LINE_LINK_PULSE_EN = ~speed100;
    assign LINE_LOOP_PMD = loopback & speed100;

    // ------------------------------------------------------------------
    // self-test checker
    // ------------------------------------------------------------------
    logic [14:0] rx_hist_q;
    logic [2:0] warm_q;
    logic fail_q;

    wire [14:0] rx_expect = prbs_nibble(rx_hist_q, prbs_long);
    wire chk = bist_run & mii_en & rx_q.en;
    wire warm = (warm_q == phy_cfg_pkg::BIST_WARM_NIBBLES);
    wire miss = chk & warm & (rx_expect[3:0] != rx_q.data);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_hist_q <= 15'h0000;
            warm_q <= 3'h0;
            fail_q <= 1'b0;
            bist_ok_q <= 1'b0;
        end else if (pc_wr) begin
            warm_q <= 3'h0;
            fail_q <= 1'b0;
            bist_ok_q <= 1'b0;
        end else if (chk) begin
            rx_hist_q <= {rx_hist_q[10:0], rx_q.data};
            if (!warm) begin
                warm_q <= warm_q + 3'h1;
            end else if (miss) begin
                fail_q <= 1'b1;
                bist_ok_q <= 1'b0;
            end else if (!fail_q) begin
                bist_ok_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // indicators on the shared strap pins
    // ------------------------------------------------------------------
    logic [4:0] ind_q;
    logic speed_ind_q;

    wire [4:0] ind_act = {rx_act, phy_tx_en & ~isolate, link_good, col_d, full_dup};
    wire dup_pin = pol_strap_q ? (ind_act[0] ^ strap_q[0]) : ind_act[0];
    wire [4:0] ind_d = {ind_act[4:1] ^ strap_q[4:1], dup_pin};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ind_q <= 5'h00;
            speed_ind_q <= 1'b0;
        end else begin
            ind_q <= ind_d;
            speed_ind_q <= speed100;
        end
    end

    assign ADDRESS_STRAP_OUT = ind_q;
    assign ADDRESS_STRAP_OE_B = straps_done ? 5'h00 : 5'h1F;
    assign SPEED_INDICATOR_OUT = speed_ind_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [15:0] phy_status_reg;
    logic [15:0] pc_read;

    always_comb begin
        phy_status_reg = 16'h0000;
        phy_status_reg[phy_cfg_pkg::PS_LINK] = link_good;
        phy_status_reg[phy_cfg_pkg::PS_SPEED10] = ~speed100;
        phy_status_reg[phy_cfg_pkg::PS_FULL_DUPLEX] = full_dup;
        phy_status_reg[phy_cfg_pkg::PS_LOOPBACK] = loopback;
        phy_status_reg[phy_cfg_pkg::PS_ISOLATE] = isolate;
        pc_read = phy_control_reg_q;
        pc_read[phy_cfg_pkg::PC_BIST_STATUS] = bist_ok_q;
    end

    wire [15:0] rd_sel = hit_bc ? basic_control_reg_q : hit_ps ? phy_status_reg : pc_read;

    assign PRDATA = {16'h0000, hit_any ? rd_sel : 16'h0000};
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit_any;

endmodule : phy_led_isolate_loopback_bist

/* File: verification/mac_mii_model.sv */
// behavioural mac streaming counting nibbles on the transmit side
`timescale 1ns/1ns
module mac_mii_model (
    input wire logic MII_CLK,
    input wire logic go,
    output logic [3:0] TXD,
    output logic TX_EN,
    output logic TX_ER
);
    logic [3:0] cnt_q = 4'h0;
    initial begin
        TXD = 4'h5;
        TX_EN = 1'b0;
    end
    assign TX_ER = 1'b0;
    // outside frames data toggles so stale nibbles never pass as valid
    always @(posedge MII_CLK) begin
        TX_EN <= go;
        TXD <= go ? cnt_q : ~TXD;
        cnt_q <= go ? cnt_q + 4'h1 : 4'h0;
    end
endmodule : mac_mii_model

/* File: verification/phy_led_isolate_loopback_bist_assertions.sv */
// assertion checker for the indicator, duplex, isolate and loopback block
`timescale 1ns/1ns
module phy_led_isolate_loopback_bist_assertions (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [4:0] ADDRESS_STRAP_INPUT,
    input wire logic [4:0] ADDRESS_STRAP_OUT,
    input wire logic [4:0] ADDRESS_STRAP_OE_B,
    input wire logic INDICATOR_POLARITY_STRAP,
    input wire logic SPEED_INDICATOR_OUT,
    input wire logic CRS,
    input wire logic COL,
    input wire logic MII_OE_B,
    input wire logic LINE_TX_EN,
    input wire logic LINE_TX_ER,
    input wire logic LINE_LINK_PULSE_EN,
    input wire logic LINE_LOOP_PMD
);
    logic [4:0] strap_q;
    logic pol_q;
    logic [9:0] idx;
    logic mapped;
    logic dup_act;
    logic col_act;
    assign idx = PADDR[11:2];
    assign mapped = idx[9:5] == 5'h00 && (idx[4:0] == phy_cfg_pkg::BASIC_CTRL_IDX
        || idx[4:0] == phy_cfg_pkg::PHY_STATUS_IDX || idx[4:0] == phy_cfg_pkg::PHY_CTRL_IDX);
    assign dup_act = ADDRESS_STRAP_OE_B == 5'h00 && (ADDRESS_STRAP_OUT[0] ^ (pol_q & strap_q[0]));
    assign col_act = ADDRESS_STRAP_OUT[1] ^ strap_q[1];
    // --------------------------------------------------------------------
    // straps as the pins show them before the indicators drive
    // --------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_q <= 5'h00;
            pol_q <= 1'b0;
        end else if (&ADDRESS_STRAP_OE_B) begin
            strap_q <= ADDRESS_STRAP_INPUT;
            pol_q <= INDICATOR_POLARITY_STRAP;
        end
    end
    // --------------------------------------------------------------------
    // properties
    // --------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_full;
        dup_act [*8];
    endsequence
    a_col_with_crs: assert property (COL |-> CRS)
        else $error("collision shown without carrier");
    a_full_col_off: assert property (s_full ##1 s_full |-> !col_act && !COL)
        else $error("collision shown in full duplex");
    a_speed_pulses: assert property ($changed(SPEED_INDICATOR_OUT)
        |-> ##[0:2] (LINE_LINK_PULSE_EN != SPEED_INDICATOR_OUT))
        else $error("link pulses disagree with speed");
    a_pmd_loop_fast: assert property ($rose(LINE_LOOP_PMD) |-> ##[0:2] SPEED_INDICATOR_OUT)
        else $error("medium loop at low speed");
    a_loop_quiet: assert property (LINE_LOOP_PMD [*8] |-> !LINE_TX_EN && !LINE_TX_ER)
        else $error("data reached the medium in loopback");
    a_iso_quiet: assert property (MII_OE_B [*8] |-> !LINE_TX_EN && !LINE_TX_ER)
        else $error("data sent while isolated");
    a_unmapped_err: assert property (PSEL && PENABLE && !mapped |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (PSEL && PENABLE && mapped
        |-> PREADY && !PSLVERR && PRDATA[31:16] == 16'h0)
        else $error("mapped access refused");
    c_col: cover property (COL);
    c_pmd_loop: cover property (LINE_LOOP_PMD);
    c_iso_access: cover property (MII_OE_B && PSEL && PENABLE);
endmodule : phy_led_isolate_loopback_bist_assertions

/* File: verification/test_phy_led_isolate_loopback_bist.sv */
// self-checking bench for the indicator, duplex, isolate, loopback and self-test block
`timescale 1ns/1ns
module test_phy_led_isolate_loopback_bist;
    localparam logic [4:0] BC = phy_cfg_pkg::BASIC_CTRL_IDX;
    localparam logic [4:0] PS = phy_cfg_pkg::PHY_STATUS_IDX;
    localparam logic [4:0] PC = phy_cfg_pkg::PHY_CTRL_IDX;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic mclk = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] strap = 5'h0B;
    logic an_spd = 1'b1;
    logic an_fd = 1'b1;
    logic an_pd = 1'b0;
    logic nlp = 1'b0;
    logic vpkt = 1'b0;
    logic sd = 1'b1;
    logic pol = 1'b1;
    logic go = 1'b0;
    logic [3:0] line_rxd = 4'h0;
    logic line_dv = 1'b0;
    logic mon = 1'b0;
    logic [3:0] lastrx;
    logic [31:0] rdata, prdata;
    logic rerr, pready, pslverr, spd, crs, col, rx_dv, iso, ltx_en, lpe, lpmd, tx_en, tx_er;
    logic [3:0] rxd, txd;
    logic [4:0] sout, oe_b;
    int nrx, checks = 0, miscompares = 0;
    wire [4:0] pin = (oe_b & strap) | (~oe_b & sout);
    always #2 CLK = ~CLK;
    always #16 mclk = ~mclk;
    always @(posedge CLK) line_rxd <= line_rxd + 4'h1;
    phy_led_isolate_loopback_bist #(.LINK_LOSS_CYCLES(200)) dut_u (
        .CLK(CLK), .RST_B(RST_B), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADDRESS_STRAP_INPUT(pin), .ADDRESS_STRAP_OUT(sout), .ADDRESS_STRAP_OE_B(oe_b),
        .INDICATOR_POLARITY_STRAP(pol), .SPEED_INDICATOR_OUT(spd), .AN_SPEED100(an_spd),
        .AN_FULL_DUPLEX(an_fd), .AN_PARALLEL_DETECT(an_pd), .SIGNAL_DETECT(sd),
        .NORMAL_LINK_PULSE(nlp), .VALID_PACKET(vpkt), .MII_LINK_CLK(mclk), .TXD(txd),
        .TX_EN(tx_en), .TX_ER(tx_er), .TX_CLK(), .RX_CLK(), .RXD(rxd), .RX_DV(rx_dv),
        .RX_ER(), .CRS(crs), .COL(col), .MII_OE_B(iso), .LINE_RXD(line_rxd),
        .LINE_RX_DV(line_dv), .LINE_RX_ER(1'b0), .LINE_TXD(), .LINE_TX_EN(ltx_en),
        .LINE_TX_ER(), .LINE_LINK_PULSE_EN(lpe), .LINE_LOOP_PMD(lpmd));
    mac_mii_model mac_u (.MII_CLK(mclk), .go(go), .TXD(txd), .TX_EN(tx_en), .TX_ER(tx_er));
    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] wd);
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {5'h00, i, 2'b00};
        pwdata <= wd;
        @(posedge CLK);
        penable <= 1'b1;
        do @(posedge CLK); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [4:0] i, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk(rdata & m, e);
    endtask : rd
    task automatic wled(input logic [4:0] e);
        for (int n = 0; n < 40 && sout !== e; n++) @(posedge CLK);
        chk({27'h0, sout}, {27'h0, e});
    endtask : wled
    task automatic pulse(input logic v);
        nlp <= !v;
        vpkt <= v;
        repeat (4) @(posedge CLK);
        nlp <= 1'b0;
        vpkt <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask : pulse
    task automatic do_reset(input logic [4:0] s);
        RST_B <= 1'b0;
        strap <= s;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (10) @(posedge CLK);
    endtask : do_reset
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        if (mon && rx_dv === 1'b1) begin
            if (nrx != 0) chk({28'h0, rxd}, {28'h0, lastrx + 4'h1});
            lastrx = rxd;
            nrx++;
        end
    end
    // --------------------------------------------------------------------
    // tests
    // --------------------------------------------------------------------
    initial begin
        do_reset(5'h0B);
        rd(BC, 32'hFFFFFFFF, 32'h3100);
        rd(PC, 32'hFFFF, 32'h000B);
        apb(1'b0, 5'h01, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk({31'h0, spd}, 32'h1);
        wled(5'h0E);
        sd <= 1'b0;
        wled(5'h0A);
        sd <= 1'b1;
        $display("test reset state done");
        for (int m = 0; m < 3; m++) begin
            an_fd <= m != 1;
            an_pd <= m == 2;
            wled(m == 0 ? 5'h0E : 5'h0F);
            rd(PS, 32'h4, m == 0 ? 32'h4 : 32'h0);
            go <= 1'b1;
            repeat (40) @(posedge CLK);
            chk({31'h0, crs}, {31'h0, m != 0});
            line_dv <= 1'b1;
            repeat (20) @(posedge CLK);
            chk({31'h0, col}, {31'h0, m != 0});
            chk({27'h0, sout}, m == 0 ? 32'h16 : 32'h15);
            go <= 1'b0;
            line_dv <= 1'b0;
            repeat (20) @(posedge CLK);
        end
        $display("test duplex done");
        an_fd <= 1'b1;
        an_pd <= 1'b0;
        an_spd <= 1'b0;
        wled(5'h0A);
        chk({31'h0, spd}, 32'h0);
        repeat (6) pulse(1'b0);
        chk({27'h0, sout}, 32'h0A);
        pulse(1'b0);
        wled(5'h0E);
        repeat (150) @(posedge CLK);
        chk({27'h0, sout}, 32'h0E);
        repeat (60) @(posedge CLK);
        wled(5'h0A);
        pulse(1'b1);
        wled(5'h0E);
        $display("test link done");
        apb(1'b1, BC, 32'h0000);
        apb(1'b1, BC, 32'h4000);
        rd(PS, 32'h8, 32'h8);
        nrx = 0;
        mon = 1'b1;
        go <= 1'b1;
        repeat (80) @(posedge CLK);
        go <= 1'b0;
        repeat (40) @(posedge CLK);
        mon = 1'b0;
        chk(nrx, 32'd10);
        chk({31'h0, lpe}, 32'h1);
        apb(1'b1, BC, 32'h6000);
        repeat (10) @(posedge CLK);
        chk({31'h0, lpmd}, 32'h1);
        $display("test loopback done");
        apb(1'b1, BC, 32'h4000);
        for (int l = 0; l < 2; l++) begin
            apb(1'b1, PC, {21'h0, l[0], 10'h20B});
            for (int n = 0; n < 100 && rdata[8] !== 1'b1; n++) apb(1'b0, PC, 32'h0);
            chk(rdata & 32'h100, 32'h100);
            line_dv <= 1'b1;
            apb(1'b1, BC, 32'h0000);
            repeat (100) @(posedge CLK);
            apb(1'b1, BC, 32'h4000);
            line_dv <= 1'b0;
            repeat (200) @(posedge CLK);
            rd(PC, 32'h100, 32'h0);
        end
        $display("test self test done");
        apb(1'b1, BC, 32'h0400);
        repeat (4) @(posedge CLK);
        chk({31'h0, iso}, 32'h1);
        rd(PS, 32'h10, 32'h10);
        go <= 1'b1;
        repeat (40) @(posedge CLK);
        chk({31'h0, ltx_en}, 32'h0);
        go <= 1'b0;
        apb(1'b1, BC, 32'h0000);
        apb(1'b1, PC, 32'h0000);
        repeat (4) @(posedge CLK);
        chk({31'h0, iso}, 32'h0);
        do_reset(5'h00);
        chk({31'h0, iso}, 32'h1);
        rd(PC, 32'h1F, 32'h0);
        rd(PS, 32'h10, 32'h10);
        pol <= 1'b0;
        do_reset(5'h0B);
        wled(5'h0B);
        $display("test isolate done");
        end_of_test();
    end
    initial begin
        repeat (30000) @(posedge CLK);
        miscompares++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : test_phy_led_isolate_loopback_bist

bind phy_led_isolate_loopback_bist phy_led_isolate_loopback_bist_assertions chk_u (
    .CLK, .RST_B, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .ADDRESS_STRAP_INPUT,
    .ADDRESS_STRAP_OUT, .ADDRESS_STRAP_OE_B, .INDICATOR_POLARITY_STRAP, .SPEED_INDICATOR_OUT,
    .CRS, .COL, .MII_OE_B, .LINE_TX_EN, .LINE_TX_ER, .LINE_LINK_PULSE_EN, .LINE_LOOP_PMD);
